/* src/sacc_map.vh */
// Purpose: Constants for the serial access error checker
// Assumes: 20 MHz device clock, byte-framed serial accesses
// Notes: Offsets, field positions, reset values and frame lengths
`ifndef SACC_MAP_VH
`define SACC_MAP_VH

// ****************************************
// Register offsets
// ****************************************
`define SACC_ADDR_STATUS 7'h00
`define SACC_ADDR_CONTROL 7'h01
`define SACC_ADDR_USER 7'h02
`define SACC_ADDR_ERROR 7'h06
`define SACC_ADDR_ERR_EN 7'h07

// ****************************************
// Field positions, shared by enable and flag registers; chip select enable bit sits in control, read bit in the command byte
// ****************************************
`define SACC_BIT_BUSY_WR 6
`define SACC_BIT_SCLK_CNT 5
`define SACC_BIT_READ 4
`define SACC_BIT_WRITE 3
`define SACC_BIT_CRC 2
`define SACC_BIT_CS_EN 0
`define SACC_BIT_RNW 7

// ****************************************
// Reset values
// ****************************************
`define SACC_RST_ERR_EN 8'h40
`define SACC_RST_CONTROL 8'h00
`define SACC_RST_USER 8'h00
`define SACC_RST_ERROR 8'h00

// ****************************************
// Frame lengths and checksum
// ****************************************
`define SACC_BITS_CMD 6'h08
`define SACC_BITS_DATA 6'h10
`define SACC_BITS_CRC 6'h18
`define SACC_CRC_POLY 8'h07
`define SACC_CRC_INIT 8'h00

`endif

/* src/sacc_checker.v */
// Purpose: Serial host access with busy, clock count, address and checksum checks
// Assumes: Host is mode-0 style master; serial pins are asynchronous to ref_clk_i
// Notes: Frame is command byte (bit 7 read, 6:0 address), data byte, optional checksum
`timescale 1ns/10ps
`include "sacc_map.vh"

module sacc_checker
(
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // Serial pins from the host
  input wire sclk_i,
  input wire cs_n_i,
  input wire mosi_i,
  output wire miso_o,
  output wire miso_oe_o,
  // Converter busy indications, same clock domain
  input wire fuse_copy_busy_i,
  input wire calib_busy_i,
  // Register contents seen by the rest of the device
  output wire [7:0] error_check_enable_o,
  output wire [7:0] error_flags_o,
  output wire chip_select_enable_o,
  output wire [7:0] user_reg_o
);

  // ****************************************
  // Functions
  // ****************************************

  // One bit of the checksum shift register
  function [7:0] crc_bit;
    input [7:0] crc;
    input din;
    begin
      if (crc[7] ^ din)
      begin
        crc_bit = {crc[6:0], 1'b0} ^ `SACC_CRC_POLY;
      end
      else
      begin
        crc_bit = {crc[6:0], 1'b0};
      end
    end
  endfunction

  // Checksum over one byte, msb first
  function [7:0] crc_byte;
    input [7:0] crc;
    input [7:0] din;
    integer i;
    reg [7:0] c;
    begin
      c = crc;
      for (i = 7; i >= 0; i = i - 1)
      begin
        c = crc_bit(c, din[i]);
      end
      crc_byte = c;
    end
  endfunction

  // Address exists in the map
  function addr_valid;
    input [6:0] a;
    begin
      addr_valid = (a == `SACC_ADDR_STATUS) || (a == `SACC_ADDR_CONTROL) ||
                   (a == `SACC_ADDR_USER) || (a == `SACC_ADDR_ERROR) ||
                   (a == `SACC_ADDR_ERR_EN);
    end
  endfunction

  // Address exists and accepts writes
  function addr_writable;
    input [6:0] a;
    begin
      addr_writable = addr_valid(a) && (a != `SACC_ADDR_STATUS);
    end
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  reg [2:0] sclk_sync_q;
  reg [2:0] cs_sync_q;
  reg [1:0] mosi_sync_q;

  // Two flops before use, third flop only for edge finding
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sclk_sync_q <= 3'h0;
      cs_sync_q <= 3'h7;
      mosi_sync_q <= 2'h0;
    end
    else
    begin
      sclk_sync_q <= {sclk_sync_q[1:0], sclk_i};
      cs_sync_q <= {cs_sync_q[1:0], cs_n_i};
      mosi_sync_q <= {mosi_sync_q[0], mosi_i};
    end
  end

  // Pin edges after the synchronisers; serial clocks only count inside a frame
  wire cs_active = ~cs_sync_q[1];
  wire sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2] & cs_active;
  wire sclk_fall = ~sclk_sync_q[1] & sclk_sync_q[2] & cs_active;
  wire frame_end = cs_sync_q[1] & ~cs_sync_q[2];
  wire frame_start = ~cs_sync_q[1] & cs_sync_q[2];
  wire mosi_s = mosi_sync_q[1];

  // ****************************************
  // Registers
  // ****************************************
  // Map registers; low two enable bits are plain storage
  reg [7:0] err_en_q;
  reg [7:0] control_q;
  reg [7:0] user_q;
  reg [7:0] error_q;
  reg [7:0] error_d;

  wire cs_en = control_q[`SACC_BIT_CS_EN];
  // Busy and checksum checks are plain one-bit enables; count, read and write checks also need the chip select enable
  wire busy_chk = err_en_q[`SACC_BIT_BUSY_WR];
  wire sclk_chk = err_en_q[`SACC_BIT_SCLK_CNT] & cs_en;
  wire read_chk = err_en_q[`SACC_BIT_READ] & cs_en;
  wire write_chk = err_en_q[`SACC_BIT_WRITE] & cs_en;
  wire crc_chk = err_en_q[`SACC_BIT_CRC];
  wire dev_busy = fuse_copy_busy_i | calib_busy_i;

  // ****************************************
  // Frame shifter
  // ****************************************
  // Six count bits cover the longest frame; count saturates instead of wrapping
  reg [5:0] bit_cnt_q;
  reg [7:0] shift_q;
  reg [7:0] cmd_q;
  reg [7:0] wdata_q;
  reg [7:0] wcrc_q;
  reg [15:0] tx_q;
  reg miso_q;
  reg rd_err_q;

  // Shift and count values taken at the next serial clock rise
  wire [7:0] shift_nx = {shift_q[6:0], mosi_s};
  wire [5:0] cnt_nx = bit_cnt_q + 6'h01;

  // Read data for a given address; unmapped reads return zero
  reg [7:0] rd_mux;
  always @*
  begin
    case (shift_nx[6:0])
      `SACC_ADDR_STATUS: rd_mux = {6'h00, calib_busy_i, fuse_copy_busy_i};
      `SACC_ADDR_CONTROL: rd_mux = control_q;
      `SACC_ADDR_USER: rd_mux = user_q;
      `SACC_ADDR_ERROR: rd_mux = error_q;
      `SACC_ADDR_ERR_EN: rd_mux = err_en_q;
      default: rd_mux = 8'h00;
    endcase
  end

  // Count clocks and capture bytes within each framed access
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bit_cnt_q <= 6'h00;
      shift_q <= 8'h00;
      cmd_q <= 8'h00;
      wdata_q <= 8'h00;
      wcrc_q <= 8'h00;
      tx_q <= 16'h0000;
      miso_q <= 1'b0;
      rd_err_q <= 1'b0;
    end
    else
    begin
      // Read error is a one-cycle pulse into the sticky flag logic
      rd_err_q <= 1'b0;
      if (frame_start)
      begin
        bit_cnt_q <= 6'h00; // Chip select delimits each access
        miso_q <= 1'b0;
      end
      else if (sclk_rise)
      begin
        shift_q <= shift_nx;
        // Saturate so a runaway clock cannot wrap into a legal count
        if (bit_cnt_q != 6'h3f)
        begin
          bit_cnt_q <= cnt_nx;
        end
        if (cnt_nx == `SACC_BITS_CMD)
        begin
          cmd_q <= shift_nx;
          // Read data followed by its checksum
          tx_q <= {rd_mux, crc_byte(crc_byte(`SACC_CRC_INIT, shift_nx), rd_mux)};
          rd_err_q <= shift_nx[`SACC_BIT_RNW] & ~addr_valid(shift_nx[6:0]);
        end
        if (cnt_nx == `SACC_BITS_DATA)
        begin
          wdata_q <= shift_nx;
        end
        if (cnt_nx == `SACC_BITS_CRC)
        begin
          wcrc_q <= shift_nx;
        end
      end
      else if (sclk_fall && bit_cnt_q >= `SACC_BITS_CMD)
      begin
        // Host samples on the rising edge, so drive on the falling one
        miso_q <= tx_q[15] & cmd_q[`SACC_BIT_RNW];
        tx_q <= {tx_q[14:0], 1'b0};
      end
    end
  end

  // Enable follows synchronised chip select, so it lags the pin by two clocks
  assign miso_o = miso_q;
  assign miso_oe_o = cs_active;

  // ****************************************
  // End of frame checks
  // ****************************************
  // Decided once, on the synchronised chip select rise, from the final count
  wire is_write = (bit_cnt_q >= `SACC_BITS_CMD) & ~cmd_q[`SACC_BIT_RNW];
  wire [5:0] need_bits = crc_chk ? `SACC_BITS_CRC : `SACC_BITS_DATA;
  wire enough = bit_cnt_q >= need_bits;
  wire [7:0] exp_crc = crc_byte(crc_byte(`SACC_CRC_INIT, cmd_q), wdata_q);
  wire crc_bad = crc_chk & (wcrc_q != exp_crc);
  wire wr_target_ok = addr_writable(cmd_q[6:0]);
  wire wr_busy = frame_end & is_write & enough & dev_busy;
  wire wr_bad_addr = frame_end & is_write & enough & ~wr_target_ok;
  wire wr_crc_fail = frame_end & is_write & enough & ~dev_busy & wr_target_ok & crc_bad;
  // Busy, unmapped, short and corrupt writes never reach a register
  wire wr_commit = frame_end & is_write & enough & ~dev_busy & wr_target_ok & ~crc_bad;
  wire cnt_bad = frame_end & (bit_cnt_q[2:0] != 3'h0) & sclk_chk;

  // Sticky flags; set beats a same-cycle clear
  always @*
  begin
    error_d = error_q;
    if (wr_commit && cmd_q[6:0] == `SACC_ADDR_ERROR)
    begin
      error_d = error_q & ~wdata_q; // Write one to clear
    end
    if (wr_busy && busy_chk)
    begin
      error_d[`SACC_BIT_BUSY_WR] = 1'b1;
    end
    if (cnt_bad)
    begin
      error_d[`SACC_BIT_SCLK_CNT] = 1'b1;
    end
    if (rd_err_q && read_chk)
    begin
      error_d[`SACC_BIT_READ] = 1'b1;
    end
    if (wr_bad_addr && write_chk)
    begin
      error_d[`SACC_BIT_WRITE] = 1'b1;
    end
    if (wr_crc_fail)
    begin
      error_d[`SACC_BIT_CRC] = 1'b1;
    end
  end

  // Register file updates
  always @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      err_en_q <= `SACC_RST_ERR_EN;
      control_q <= `SACC_RST_CONTROL;
      user_q <= `SACC_RST_USER;
      error_q <= `SACC_RST_ERROR;
    end
    else
    begin
      error_q <= error_d;
      if (wr_commit)
      begin
        case (cmd_q[6:0])
          `SACC_ADDR_CONTROL: control_q <= wdata_q;
          `SACC_ADDR_USER: user_q <= wdata_q;
          `SACC_ADDR_ERR_EN: err_en_q <= wdata_q;
          default: user_q <= user_q;
        endcase
      end
    end
  end

  // Register contents for the rest of the device
  assign error_check_enable_o = err_en_q;
  assign error_flags_o = error_q;
  assign chip_select_enable_o = cs_en;
  assign user_reg_o = user_q;

endmodule

/* bench/sacc_monitor.sv */
// Purpose: Port assertions for the serial access checker
// Assumes: One clock domain, reset active low
// Notes: Flag bits share positions with enable bits
`timescale 1ns/10ps
module sacc_monitor
(
  // Clock and reset
  input wire ref_clk_i,
  input wire rst_n_i,
  // Serial pins
  input wire sclk_i,
  input wire cs_n_i,
  input wire mosi_i,
  input wire miso_o,
  input wire miso_oe_o,
  // Busy inputs and registers
  input wire fuse_copy_busy_i,
  input wire calib_busy_i,
  input wire [7:0] error_check_enable_o,
  input wire [7:0] error_flags_o,
  input wire chip_select_enable_o,
  input wire [7:0] user_reg_o
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // ****************
  // Flags rise only when their checks are armed
  // ****************
  a_busy_flag_en:
    assert property ($rose(error_flags_o[6]) |-> error_check_enable_o[6]) else $error("busy flag unarmed");
  a_count_flag_en:
    assert property ($rose(error_flags_o[5]) |-> error_check_enable_o[5] && chip_select_enable_o)
      else $error("count flag unarmed");
  a_read_flag_en:
    assert property ($rose(error_flags_o[4]) |-> error_check_enable_o[4] && chip_select_enable_o)
      else $error("read flag unarmed");
  a_write_flag_en:
    assert property ($rose(error_flags_o[3]) |-> error_check_enable_o[3] && chip_select_enable_o)
      else $error("write flag unarmed");
  a_crc_flag_en:
    assert property ($rose(error_flags_o[2]) |-> error_check_enable_o[2]) else $error("crc flag unarmed");
  // Frame-end decisions never land deep inside a frame
  a_flags_quiet:
    assert property ((!cs_n_i)[*5] |-> $stable({error_flags_o[6:5], error_flags_o[3:2]}))
      else $error("flag moved in frame");
  a_commit_after:
    assert property (!$stable(user_reg_o) |-> cs_n_i && $past(cs_n_i)) else $error("commit in frame");
  a_oe_idle:
    assert property (cs_n_i[*4] |-> !miso_oe_o) else $error("driving while deselected");
  a_oe_framed:
    assert property ((!cs_n_i)[*4] |-> miso_oe_o) else $error("not driving inside frame");
endmodule

/* bench/sacc_host.sv */
// Purpose: Host serial master model
// Assumes: Mode-0 framing, 400 ns serial clock
// Notes: Serial clock stands low outside frames
`timescale 1ns/10ps
module sacc_host
(
  // Serial pins
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  initial
  begin
    sclk_o <= 1'b0;
    cs_n_o <= 1'b1;
    mosi_o <= 1'b0;
  end
  // Non-blocking drive, so a change that lands on a device clock edge is seen after it
  // One framed access of n clocks, msb first; whole bytes unless told otherwise
  task automatic xfer(input logic [23:0] dat, input int n, output logic [23:0] rx);
    rx = 24'h000000;
    #237 cs_n_o <= 1'b0;
    #400;
    for (int i = n - 1; i >= 0; i--)
    begin
      mosi_o <= dat[i];
      #200 sclk_o <= 1'b1;
      rx = {rx[22:0], miso_i};
      #200 sclk_o <= 1'b0;
    end
    #400 cs_n_o <= 1'b1;
    mosi_o <= ~mosi_o; // Released line must not keep its value
    #600;
  endtask
endmodule

/* bench/sacc_checker_bench.sv */
// Purpose: Self-checking bench for the serial access checker
// Assumes: Host model frames every access
// Notes: One task per scenario
`timescale 1ns/10ps
`include "sacc_map.vh"
`define SACC_CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h want %h", $time, g, e); end end
module sacc_checker_bench;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic fuse_copy_busy_i = 1'b0;
  logic calib_busy_i = 1'b0;
  wire sclk_w, cs_n_w, mosi_w, miso_w, oe_w, cs_en_w;
  wire [7:0] en_w, flags_w, user_w;
  logic [23:0] rx;
  int bad_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  sacc_checker uut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_w), .cs_n_i(cs_n_w),
    .mosi_i(mosi_w), .miso_o(miso_w), .miso_oe_o(oe_w), .fuse_copy_busy_i(fuse_copy_busy_i),
    .calib_busy_i(calib_busy_i), .error_check_enable_o(en_w), .error_flags_o(flags_w),
    .chip_select_enable_o(cs_en_w), .user_reg_o(user_w));
  sacc_host host (.sclk_o(sclk_w), .cs_n_o(cs_n_w), .mosi_o(mosi_w), .miso_i(oe_w ? miso_w : ~sclk_w));
  // ****************
  // Helpers
  // ****************
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--)
      c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
    return c;
  endfunction
  // Short counts cut the frame early, checksum rides in the tail
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input int n);
    host.xfer({1'b0, a, d, crc8({1'b0, a, d})} >> (24 - n), n, rx);
  endtask
  task automatic rd(input logic [6:0] a, input int n);
    host.xfer({1'b1, a, 16'h0000} >> (24 - n), n, rx);
  endtask
  task automatic busy(input logic [1:0] b);
    @(posedge ref_clk_i);
    {fuse_copy_busy_i, calib_busy_i} <= b;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_reset;
    `SACC_CHK({en_w, flags_w, user_w, cs_en_w}, 25'h0800000)
    rd(`SACC_ADDR_ERR_EN, 16);
    `SACC_CHK(rx[7:0], 8'h40)
  endtask
  task automatic t_count;
    wr(`SACC_ADDR_CONTROL, 8'h01, 16);
    wr(`SACC_ADDR_ERR_EN, 8'h60, 16);
    wr(`SACC_ADDR_USER, 8'ha5, 16);
    wr(`SACC_ADDR_USER, 8'h3c, 15);
    `SACC_CHK({flags_w, user_w}, 16'h20a5)
    wr(`SACC_ADDR_ERROR, 8'hff, 16);
    wr(`SACC_ADDR_CONTROL, 8'h00, 16);
    wr(`SACC_ADDR_USER, 8'h3c, 15);
    `SACC_CHK(flags_w, 8'h00)
  endtask
  task automatic t_busy;
    for (int k = 1; k < 3; k++)
    begin
      busy(k[1:0]);
      wr(`SACC_ADDR_USER, 8'h11, 16);
      busy(2'b00);
      `SACC_CHK({flags_w, user_w}, 16'h40a5)
      wr(`SACC_ADDR_ERROR, 8'hff, 16);
    end
    wr(`SACC_ADDR_ERR_EN, 8'h00, 16);
    busy(2'b11);
    wr(`SACC_ADDR_USER, 8'h11, 16);
    busy(2'b00);
    `SACC_CHK(flags_w, 8'h00)
  endtask
  task automatic t_addr;
    wr(`SACC_ADDR_CONTROL, 8'h01, 16);
    wr(`SACC_ADDR_ERR_EN, 8'h18, 16);
    rd(7'h05, 16);
    `SACC_CHK(flags_w, 8'h10)
    wr(`SACC_ADDR_ERROR, 8'hff, 16);
    wr(`SACC_ADDR_STATUS, 8'h55, 16);
    `SACC_CHK(flags_w, 8'h08)
    wr(`SACC_ADDR_ERROR, 8'hff, 16);
    busy(2'b01);
    rd(`SACC_ADDR_STATUS, 16);
    busy(2'b00);
    `SACC_CHK({flags_w, rx[7:0]}, 16'h0002)
    wr(`SACC_ADDR_CONTROL, 8'h00, 16);
    wr(7'h05, 8'h55, 16);
    `SACC_CHK(flags_w, 8'h00)
  endtask
  task automatic t_crc;
    wr(`SACC_ADDR_ERR_EN, 8'h04, 16);
    host.xfer({8'h02, 8'h77, ~crc8(16'h0277)}, 24, rx);
    `SACC_CHK({flags_w, user_w}, 16'h04a5)
    wr(`SACC_ADDR_ERROR, 8'hff, 24);
    wr(`SACC_ADDR_USER, 8'h77, 24);
    rd(`SACC_ADDR_USER, 24);
    `SACC_CHK({flags_w, rx[15:0]}, {16'h0077, crc8(16'h8277)})
  endtask
  // ****************
  // Run control
  // ****************
  task automatic test_done;
    $display("compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Ceiling is about six times the expected run
  always @(posedge ref_clk_i)
  begin
    cycles++;
    if (cycles == 30000)
    begin
      bad_count++;
      test_done();
    end
  end
  initial
  begin
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    t_reset();
    t_count();
    t_busy();
    t_addr();
    t_crc();
    test_done();
  end
endmodule
bind sacc_checker sacc_monitor mon (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i),
  .cs_n_i(cs_n_i), .mosi_i(mosi_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
  .fuse_copy_busy_i(fuse_copy_busy_i), .calib_busy_i(calib_busy_i),
  .error_check_enable_o(error_check_enable_o), .error_flags_o(error_flags_o),
  .chip_select_enable_o(chip_select_enable_o), .user_reg_o(user_reg_o));
